// ===== dv/etsp_ext_model.sv
// Behavioural model of the external equipment on the extension connector
`timescale 1ns/1ps
module etsp_ext_model #(
  parameter int HOLD = 8
) (
  // Clock
  input  wire logic clk,
  // Commands from the bench
  input  wire logic press,
  input  wire logic ltrg_fire,
  input  wire logic clk_run,
  // Pin levels
  output logic      start_n,
  output logic      link_trg_n,
  output logic      link_clk
);
  int         hold_r = 0;
  int         lt_r   = 0;
  logic [1:0] div_r  = 2'h0;

  assign start_n    = (hold_r == 0);
  assign link_trg_n = (lt_r == 0);
  // Pulled up and still outside linked runs
  assign link_clk   = clk_run ? div_r[1] : 1'b1;

  always @(posedge clk) begin
    if (press) hold_r <= HOLD;
    else if (hold_r > 0) hold_r <= hold_r - 1;
    if (ltrg_fire) lt_r <= 2;
    else if (lt_r > 0) lt_r <= lt_r - 1;
    div_r <= div_r + 2'h1;
  end
endmodule

// ===== dv/etsp_port_bench.sv
// Self-checking testbench for the extension trigger and status port
`timescale 1ns/1ps
module etsp_port_bench;
  localparam int PW = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  etsp_pkg::etsp_mode_type mode = etsp_pkg::ETSP_MODE_DEBUG;
  logic [1:0] edge_sel = 2'h0;
  logic link_enable = 1'b0, link_master = 1'b0, share = 1'b0, crun = 1'b0;
  logic ok = 1'b0, err = 1'b0, atrg = 1'b0, clr = 1'b0, press = 1'b0, ltrg = 1'b0;
  logic op_start, op_running, lts, lcs, err_n, trg_n, ext_n, ext_lt, ext_lc;
  logic lca_o, lca_oe, lcb_o, lcb_oe, lta_o, lta_oe, ltb_o, ltb_oe;
  logic lts_hit = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  // The driving party wins, otherwise the partner or a pull-up
  wire logic lca = lca_oe ? lca_o : ext_lc;
  wire logic lcb = lcb_oe ? lcb_o : 1'b1;
  wire logic lta = lta_oe ? lta_o : ext_lt;
  wire logic ltb = ltb_oe ? ltb_o : 1'b1;

  always #10 clk = ~clk;
  always @(posedge clk) share <= ~share;

  etsp_port #(.PULSE_WIDTH(PW)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .mode(mode), .link_enable(link_enable),
    .link_master(link_master), .analyzer_edge_sel(edge_sel), .op_done_ok(ok),
    .op_done_error(err), .analyzer_trigger(atrg), .op_busy_clear(clr),
    .op_start(op_start), .op_running(op_running), .link_trigger_seen(lts),
    .external_start_input_n(ext_n), .error_output_n(err_n), .trigger_or_done_output_n(trg_n),
    .link_clock_line_a_in(lca), .link_clock_line_a_out(lca_o), .link_clock_line_a_oe(lca_oe),
    .link_clock_line_b_in(lcb), .link_clock_line_b_out(lcb_o), .link_clock_line_b_oe(lcb_oe),
    .link_trigger_line_a_in(lta), .link_trigger_line_a_out(lta_o),
    .link_trigger_line_a_oe(lta_oe), .link_trigger_line_b_in(ltb),
    .link_trigger_line_b_out(ltb_o), .link_trigger_line_b_oe(ltb_oe),
    .share_clock_in(share), .link_clock_seen(lcs));
  etsp_ext_model #(.HOLD(8)) i_ext (
    .clk(clk), .press(press), .ltrg_fire(ltrg), .clk_run(crun),
    .start_n(ext_n), .link_trg_n(ext_lt), .link_clk(ext_lc));

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle event: 0 ok, 1 error, 2 trigger, 3 abort, 4 pin, else link trigger
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: ok <= 1'b1;
      1: err <= 1'b1;
      2: atrg <= 1'b1;
      3: clr <= 1'b1;
      4: press <= 1'b1;
      default: ltrg <= 1'b1;
    endcase
    @(posedge clk);
    {ok, err, atrg, clr, press, ltrg} <= 6'h00;
    #1;
  endtask

  task automatic exp_start(input int n, input logic want);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (op_start === 1'b1) seen = 1'b1;
      if (lts === 1'b1) lts_hit = 1'b1;
    end
    chk(seen, want);
  endtask

  // Counts low cycles of both status pins over a fixed window
  task automatic meas(input logic [7:0] e_err, input logic [7:0] e_trg);
    logic [7:0] ne;
    logic [7:0] nt;
    ne = 8'h00;
    nt = 8'h00;
    repeat (12) begin
      if (err_n === 1'b0) ne++;
      if (trg_n === 1'b0) nt++;
      @(posedge clk);
      #1;
    end
    chk(ne, e_err);
    chk(nt, e_trg);
  endtask

  task automatic t_flash(input etsp_pkg::etsp_mode_type m);
    @(posedge clk);
    mode <= m;
    fire(4);
    exp_start(6, 1'b1);
    fire(0);
    meas(8'h00, PW[7:0]);
    fire(4);
    exp_start(6, 1'b1);
    fire(1);
    meas(PW[7:0], 8'h00);
    fire(4);
    exp_start(6, 1'b1);
    fire(3);
    meas(8'h00, 8'h00);
    chk(op_running, 1'b0);
    $display("flash test done");
  endtask

  task automatic t_analyzer();
    @(posedge clk);
    mode <= etsp_pkg::ETSP_MODE_ANALYZER;
    edge_sel <= etsp_pkg::EDGE_TRAILING;
    fire(4);
    exp_start(6, 1'b1);
    fire(2);
    meas(8'h00, PW[7:0]);
    fire(3);
    edge_sel <= etsp_pkg::EDGE_LEADING;
    fire(4);
    exp_start(6, 1'b0);
    exp_start(8, 1'b1);
    fire(3);
    $display("analyzer test done");
  endtask

  task automatic t_linked();
    logic [7:0] nc;
    @(posedge clk);
    edge_sel <= etsp_pkg::EDGE_TRAILING;
    link_enable <= 1'b1;
    crun <= 1'b1;
    lts_hit = 1'b0;
    fire(4);
    exp_start(12, 1'b0);
    chk(lts_hit, 1'b0);
    chk(lca_oe, 1'b0);
    // Partner clock is high two cycles of every four
    nc = 8'h00;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (lcs === 1'b1) nc++;
    end
    chk(nc, 8'h04);
    fire(5);
    exp_start(8, 1'b1);
    chk(lts_hit, 1'b1);
    fire(3);
    link_master <= 1'b1;
    crun <= 1'b0;
    lts_hit = 1'b0;
    fire(4);
    exp_start(6, 1'b1);
    chk(lts_hit, 1'b0);
    fire(2);
    chk({lta_oe, lta_o}, 8'h02);
    chk({ltb_oe, ltb_o}, 8'h02);
    meas(8'h00, PW[7:0]);
    chk(lca_o, !share);
    chk(lcb_o, !share);
    chk({lca_oe, lcb_oe, lcs}, 8'h06);
    fire(3);
    $display("linked test done");
  endtask

  task automatic t_quiet(input etsp_pkg::etsp_mode_type m, input logic starts);
    @(posedge clk);
    link_enable <= 1'b0;
    mode <= m;
    fire(4);
    exp_start(12, starts);
    fire(0);
    fire(2);
    meas(8'h00, 8'h00);
    fire(3);
    $display("quiet mode test done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({err_n, trg_n, op_running}, 8'h06);
    t_flash(etsp_pkg::ETSP_MODE_FLASH_A);
    t_flash(etsp_pkg::ETSP_MODE_FLASH_B);
    t_analyzer();
    t_linked();
    t_quiet(etsp_pkg::ETSP_MODE_PATTERN, 1'b1);
    t_quiet(etsp_pkg::ETSP_MODE_DEBUG, 1'b0);
    t_quiet(etsp_pkg::ETSP_MODE_BSCAN, 1'b0);
    test_done();
  end
endmodule

// ===== dv/etsp_port_chk.sv
// Assertion checker for the extension trigger and status port
`timescale 1ns/1ps
module etsp_port_chk #(
  parameter int PULSE_WIDTH = etsp_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Mode and events
  input  wire etsp_pkg::etsp_mode_type mode,
  input  wire logic                    link_enable,
  input  wire logic                    link_master,
  input  wire logic                    op_done_ok,
  input  wire logic                    op_done_error,
  input  wire logic                    analyzer_trigger,
  input  wire logic                    share_clock_in,
  // Watched outputs
  input  wire logic                    op_start,
  input  wire logic                    op_running,
  input  wire logic                    error_output_n,
  input  wire logic                    trigger_or_done_output_n,
  input  wire logic                    link_clock_line_a_out,
  input  wire logic                    link_clock_line_a_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Low-time counter of the trigger pin
  // ----------------------------------------------------------------
  logic [7:0] lo_r;
  logic [7:0] lo_nxt;
  wire  logic is_flash = mode inside {etsp_pkg::ETSP_MODE_FLASH_A, etsp_pkg::ETSP_MODE_FLASH_B};
  wire  logic quiet_trg = mode inside {etsp_pkg::ETSP_MODE_DEBUG, etsp_pkg::ETSP_MODE_BSCAN,
                                       etsp_pkg::ETSP_MODE_PATTERN};

  always_comb lo_nxt = trigger_or_done_output_n ? 8'h00 : lo_r + 8'h01;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) lo_r <= 8'h00;
    else lo_r <= lo_nxt;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_launch;
    op_running ##1 !op_start;
  endsequence
  property p_start_once;
    op_start |-> !$past(op_running) ##0 s_launch;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start pulse malformed");
  property p_quiet_in;
    ($past(mode) inside {etsp_pkg::ETSP_MODE_DEBUG, etsp_pkg::ETSP_MODE_BSCAN}) |-> !op_start;
  endproperty
  a_quiet_in: assert property (p_quiet_in) else $error("start in quiet mode");
  property p_err_quiet;
    !is_flash && $past(!is_flash) |-> error_output_n;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error pin active");
  property p_trg_quiet;
    quiet_trg && $past(quiet_trg) |-> trigger_or_done_output_n;
  endproperty
  a_trg_quiet: assert property (p_trg_quiet) else $error("trigger pin active");
  property p_done_ok;
    is_flash && op_running && op_done_ok && !op_done_error |=> !trigger_or_done_output_n;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("no normal end pulse");
  property p_done_err;
    is_flash && op_running && op_done_error |=> !error_output_n && !op_running;
  endproperty
  a_done_err: assert property (p_done_err) else $error("no error pulse");
  property p_ana_trg;
    mode == etsp_pkg::ETSP_MODE_ANALYZER && analyzer_trigger |=> !trigger_or_done_output_n;
  endproperty
  a_ana_trg: assert property (p_ana_trg) else $error("no internal trigger pulse");
  property p_pulse_len;
    $rose(trigger_or_done_output_n) |-> lo_r == PULSE_WIDTH;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("trigger pulse length wrong");
  property p_link_clk;
    link_enable && link_master |-> link_clock_line_a_oe
      ##1 link_clock_line_a_out == $past(share_clock_in);
  endproperty
  a_link_clk: assert property (p_link_clk) else $error("link clock not shared");
endmodule

bind etsp_port etsp_port_chk #(.PULSE_WIDTH(PULSE_WIDTH)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .mode(mode), .link_enable(link_enable),
  .link_master(link_master), .op_done_ok(op_done_ok), .op_done_error(op_done_error),
  .analyzer_trigger(analyzer_trigger), .share_clock_in(share_clock_in),
  .op_start(op_start), .op_running(op_running), .error_output_n(error_output_n),
  .trigger_or_done_output_n(trigger_or_done_output_n),
  .link_clock_line_a_out(link_clock_line_a_out), .link_clock_line_a_oe(link_clock_line_a_oe));

// ===== hdl/etsp_pkg.sv
// Package of modes, states and constants for the extension trigger and status port
//
// Contract
// R01: Flash writer modes drive error output low when a write ends in error.
// R02: Flash writer modes drive trigger output low when a write ends normally.
// R03: Flash writer modes take a low-going trigger input as start-of-write request.
// R04: Operation starts on the falling trigger input edge; analyzer mode edge is selectable.
// R05: Analyzer mode drives trigger output low for the internal trigger.
// R06: Analyzer external trigger acts only on the master; linked slaves ignore it.
// R07: Analyzer mode offers a setting choosing leading or trailing start edge.
// R08: Pattern generator mode starts output on low trigger input; outputs unused.
// R09: Two bidirectional link clock lines share a clock between linked units.
// R10: Two bidirectional link trigger lines exchange trigger events between units.
// R11: Trigger input passes two flip-flops before edge detection.
// R12: Debug adapter and boundary-scan modes hold outputs high, ignore trigger input.
package etsp_pkg;

  // ----------------------------------------------------------------
  // Function modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ETSP_MODE_DEBUG    = 3'h0,
    ETSP_MODE_BSCAN    = 3'h1,
    ETSP_MODE_ANALYZER = 3'h2,
    ETSP_MODE_PATTERN  = 3'h3,
    ETSP_MODE_FLASH_A  = 3'h4,
    ETSP_MODE_FLASH_B  = 3'h5
  } etsp_mode_type;

  // ----------------------------------------------------------------
  // Operation sequencer states, Gray coded along idle-run-done
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ETSP_ST_IDLE = 2'h0,
    ETSP_ST_RUN  = 2'h1,
    ETSP_ST_DONE = 2'h3
  } etsp_state_type;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic       PIN_IDLE_LEVEL   = 1'b1;
  localparam int         SYNC_STAGES      = 2;
  localparam int         PULSE_NS         = 1000;
  localparam int         CLK_PERIOD_NS    = 20;
  localparam int         PULSE_CYCLES     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] EDGE_TRAILING    = 2'h0;
  localparam logic [1:0] EDGE_LEADING     = 2'h1;
  localparam int         LINK_LINES       = 2;

endpackage

// ===== hdl/etsp_port.sv
// Extension connector trigger, status and link logic
`timescale 1ns/1ps
module etsp_port #(
  parameter int PULSE_WIDTH = etsp_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Mode and configuration
  input  wire etsp_pkg::etsp_mode_type mode,
  input  wire logic                   link_enable,
  input  wire logic                   link_master,
  input  wire logic [1:0]             analyzer_edge_sel,
  // Function-side events
  input  wire logic                   op_done_ok,
  input  wire logic                   op_done_error,
  input  wire logic                   analyzer_trigger,
  input  wire logic                   op_busy_clear,
  // Function-side start and status
  output logic                        op_start,
  output logic                        op_running,
  output logic                        link_trigger_seen,
  // Connector pins
  input  wire logic                   external_start_input_n,
  output logic                        error_output_n,
  output logic                        trigger_or_done_output_n,
  // Link clock lines
  input  wire logic                   link_clock_line_a_in,
  output logic                        link_clock_line_a_out,
  output logic                        link_clock_line_a_oe,
  input  wire logic                   link_clock_line_b_in,
  output logic                        link_clock_line_b_out,
  output logic                        link_clock_line_b_oe,
  // Link trigger lines
  input  wire logic                   link_trigger_line_a_in,
  output logic                        link_trigger_line_a_out,
  output logic                        link_trigger_line_a_oe,
  input  wire logic                   link_trigger_line_b_in,
  output logic                        link_trigger_line_b_out,
  output logic                        link_trigger_line_b_oe,
  // Local clock to share when master
  input  wire logic                   share_clock_in,
  output logic                        link_clock_seen
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic is_flash;
  logic is_analyzer;
  logic is_pattern;
  logic is_quiet;

  assign is_flash    = (mode == etsp_pkg::ETSP_MODE_FLASH_A) ||
                       (mode == etsp_pkg::ETSP_MODE_FLASH_B);
  assign is_analyzer = (mode == etsp_pkg::ETSP_MODE_ANALYZER);
  assign is_pattern  = (mode == etsp_pkg::ETSP_MODE_PATTERN);
  assign is_quiet    = ~(is_flash | is_analyzer | is_pattern); // see R12

  // ----------------------------------------------------------------
  // Trigger input synchroniser and edge detection
  // ----------------------------------------------------------------
  logic ext_level;
  logic ext_rise;
  logic ext_fall;

  etsp_sync #(
    .RESET_LEVEL (etsp_pkg::PIN_IDLE_LEVEL)
  ) u_ext_sync ( // see R11
    .clk       (clk),
    .sys_rst   (sys_rst),
    .async_in  (external_start_input_n),
    .level_out (ext_level),
    .rise_out  (ext_rise),
    .fall_out  (ext_fall)
  );

  // Link lines are also asynchronous pins
  logic [etsp_pkg::LINK_LINES-1:0] lt_level;
  logic [etsp_pkg::LINK_LINES-1:0] lt_fall;
  logic [etsp_pkg::LINK_LINES-1:0] lc_level;
  logic [etsp_pkg::LINK_LINES-1:0] lt_in;
  logic [etsp_pkg::LINK_LINES-1:0] lc_in;

  assign lt_in = {link_trigger_line_b_in, link_trigger_line_a_in};
  assign lc_in = {link_clock_line_b_in, link_clock_line_a_in};

  genvar gi;
  generate
    for (gi = 0; gi < etsp_pkg::LINK_LINES; gi++) begin : g_link
      etsp_sync #(
        .RESET_LEVEL (etsp_pkg::PIN_IDLE_LEVEL)
      ) u_lt_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .async_in  (lt_in[gi]),
        .level_out (lt_level[gi]),
        .rise_out  (),
        .fall_out  (lt_fall[gi])
      );
      etsp_sync #(
        .RESET_LEVEL (etsp_pkg::PIN_IDLE_LEVEL)
      ) u_lc_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .async_in  (lc_in[gi]),
        .level_out (lc_level[gi]),
        .rise_out  (),
        .fall_out  ()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Start decode
  // ----------------------------------------------------------------
  logic ext_edge;
  logic ext_ok;
  logic start_req;
  logic is_slave;

  assign is_slave = link_enable & ~link_master;

  // Trailing edge of an active-low pin is its falling edge
  always_comb begin
    ext_edge = ext_fall; // see R04
    if (is_analyzer && analyzer_edge_sel == etsp_pkg::EDGE_LEADING) begin
      ext_edge = ext_rise; // see R07
    end
  end

  // Slave analyzers take the trigger only from the link, never the pin
  assign ext_ok    = ~is_quiet & ~(is_analyzer & is_slave); // see R06
  assign start_req = (ext_ok & ext_edge) |
                     (is_analyzer & is_slave & (|lt_fall)); // see R03 R08

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  etsp_pkg::etsp_state_type st_r;
  etsp_pkg::etsp_state_type st_nxt;
  logic                     start_r;
  logic                     start_nxt;
  logic                     ok_fire;
  logic                     err_fire;

  always_comb begin
    st_nxt    = st_r;
    start_nxt = 1'b0;
    ok_fire   = 1'b0;
    err_fire  = 1'b0;
    case (st_r)
      etsp_pkg::ETSP_ST_IDLE: begin
        if (start_req) begin
          st_nxt    = etsp_pkg::ETSP_ST_RUN;
          start_nxt = 1'b1;
        end
      end
      etsp_pkg::ETSP_ST_RUN: begin
        if (is_quiet || op_busy_clear) begin
          st_nxt = etsp_pkg::ETSP_ST_IDLE;
        end else if (op_done_error) begin
          st_nxt   = etsp_pkg::ETSP_ST_DONE;
          err_fire = is_flash; // see R01
        end else if (op_done_ok) begin
          st_nxt  = etsp_pkg::ETSP_ST_DONE;
          ok_fire = is_flash; // see R02
        end
      end
      etsp_pkg::ETSP_ST_DONE: begin
        st_nxt = etsp_pkg::ETSP_ST_IDLE;
      end
      default: begin
        st_nxt = etsp_pkg::ETSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r    <= etsp_pkg::ETSP_ST_IDLE;
      start_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      start_r <= start_nxt;
    end
  end

  assign op_start   = start_r;
  assign op_running = (st_r == etsp_pkg::ETSP_ST_RUN);

  // ----------------------------------------------------------------
  // Status pin pulses
  // ----------------------------------------------------------------
  logic trig_fire;
  logic trig_hold;

  // Analyzer trigger may come at any time, not only while running
  assign trig_fire = ok_fire | (is_analyzer & analyzer_trigger); // see R05
  assign trig_hold = is_quiet | is_pattern; // see R08 R12

  etsp_pulse #(
    .WIDTH (PULSE_WIDTH)
  ) u_err_pulse (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .fire     (err_fire),
    .hold_off (~is_flash),
    .pin_n    (error_output_n)
  );

  etsp_pulse #(
    .WIDTH (PULSE_WIDTH)
  ) u_trg_pulse (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .fire     (trig_fire),
    .hold_off (trig_hold),
    .pin_n    (trigger_or_done_output_n)
  );

  // ----------------------------------------------------------------
  // Link lines
  // ----------------------------------------------------------------
  logic drive_link;
  logic lt_drv_r;
  logic lt_drv_nxt;
  logic lc_drv_r;
  logic lc_drv_nxt;

  // Master drives both pairs outside debug and boundary-scan modes; slaves listen, so no two units fight a line
  assign drive_link = link_enable & link_master & ~is_quiet; // see R09 R10

  always_comb begin
    lc_drv_nxt = share_clock_in;
    lt_drv_nxt = ~(start_req | (is_analyzer & analyzer_trigger));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lc_drv_r <= etsp_pkg::PIN_IDLE_LEVEL;
      lt_drv_r <= etsp_pkg::PIN_IDLE_LEVEL;
    end else begin
      lc_drv_r <= lc_drv_nxt;
      lt_drv_r <= lt_drv_nxt;
    end
  end

  assign link_clock_line_a_out   = lc_drv_r; // see R09
  assign link_clock_line_b_out   = lc_drv_r;
  assign link_clock_line_a_oe    = drive_link;
  assign link_clock_line_b_oe    = drive_link;
  assign link_trigger_line_a_out = lt_drv_r; // see R10
  assign link_trigger_line_b_out = lt_drv_r;
  assign link_trigger_line_a_oe  = drive_link;
  assign link_trigger_line_b_oe  = drive_link;

  assign link_trigger_seen = link_enable & ~link_master & (|lt_fall);
  assign link_clock_seen   = link_enable & ~link_master & lc_level[0];

endmodule

// ===== hdl/etsp_pulse.sv
// Fixed-length active-low pulse generator for a status pin
`timescale 1ns/1ps
module etsp_pulse #(
  parameter int WIDTH = etsp_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic fire,
  input  wire logic hold_off,
  // Pin level
  output logic      pin_n
);

  localparam int CW = $clog2(WIDTH + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          pin_n_r;
  logic          pin_n_nxt;

  always_comb begin
    cnt_nxt   = cnt_r;
    pin_n_nxt = 1'b1;
    if (hold_off) begin
      cnt_nxt = '0;
    end else if (fire) begin
      cnt_nxt   = CW'(WIDTH);
      pin_n_nxt = 1'b0;
    end else if (cnt_r > CW'(1)) begin
      cnt_nxt   = cnt_r - CW'(1);
      pin_n_nxt = 1'b0;
    end else begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r   <= '0;
      pin_n_r <= etsp_pkg::PIN_IDLE_LEVEL;
    end else begin
      cnt_r   <= cnt_nxt;
      pin_n_r <= pin_n_nxt;
    end
  end

  assign pin_n = pin_n_r;

endmodule

// ===== hdl/etsp_sync.sv
// Two-stage synchroniser with edge outputs
`timescale 1ns/1ps
module etsp_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Only sync_r reads meta_r; edges use the second stage onward
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= RESET_LEVEL;
      sync_r <= RESET_LEVEL;
      last_r <= RESET_LEVEL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~last_r;
  assign fall_out  = ~sync_r & last_r;

endmodule
